// File: src/modem_device.sv
// modem end of the data interface port: power sequence, serial link, handshake and indicators
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
//
// Contract
// - characters are 8 data, no parity, 1 stop
// - power request high on, low off
// - host drives power request low for off
// - host holds reset low at least 5 ms
// - carrier detect low while in range
// - host raises request-to-send, device pauses sending
// - device raises clear-to-send, host pauses sending
// - ring indicator pulses low while messages wait
// - status lines direction configurable, currently inactive
// - power, transmit, receive indicator patterns
// - software disable turns indicators off
// - start-up and power-down flash regardless of disable
// - host drives signals low after power off
module modem_device import modem_pkg::*; #(
	parameter int STARTUP_CYCLES   = STARTUP_CYC,
	parameter int POWERDOWN_CYCLES = POWERDOWN_CYC,
	parameter int FLASH_CYCLES     = FLASH_HALF_CYC,
	parameter int ACT_CYCLES       = ACT_CYC
) (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	// link to host
	modem_link_if.device               link,
	// serial setup
	input  wire logic [BAUD_W-1:0]     baud_div_i,
	// data toward host
	input  wire logic                  tx_valid_i,
	input  wire logic [DATA_BITS-1:0]  tx_data_i,
	output logic                       tx_ready_o,
	// data from host
	output logic                       rx_valid_o,
	output logic [DATA_BITS-1:0]       rx_data_o,
	output logic                       rx_err_o,
	input  wire logic                  rx_pause_i,
	// modem condition
	input  wire logic                  in_range_i,
	input  wire logic                  channel_locked_i,
	input  wire logic                  msg_waiting_i,
	input  wire logic                  led_disable_i,
	// status lines, user side
	input  wire logic [NUM_STATUS-1:0] status_dir_i,
	input  wire logic [NUM_STATUS-1:0] status_out_i,
	output logic [NUM_STATUS-1:0]      status_in_o,
	// power and indicators
	output logic                       powered_o,
	output logic                       power_led_o,
	output logic                       tx_led_o,
	output logic                       rx_led_o
);
	localparam int SYNC_W = 5 + NUM_STATUS;
	localparam int S_PWR  = SYNC_W - 1;
	localparam int S_RSTN = SYNC_W - 2;
	localparam int S_TXD  = SYNC_W - 3;
	localparam int S_RTS  = SYNC_W - 5;
	typedef struct packed {
		logic [SYNC_W-1:0]     sync1;      // first synchroniser stage
		logic [SYNC_W-1:0]     sync2;      // second stage, read by logic
		pwr_state_t            state;      // power sequence
		logic [TMR_W-1:0]      tmr;        // sequence timer
		logic [TMR_W-1:0]      blink_cnt;  // flash half period counter
		logic                  blink;      // flash phase
		logic [TMR_W-1:0]      tx_act;     // transmit activity stretch
		logic [TMR_W-1:0]      rx_act;     // receive activity stretch
		logic                  dcd_n;
		logic                  dsr_n;
		logic                  cts;
		logic                  ring_n;
		logic [NUM_STATUS-1:0] st_o;
		logic [NUM_STATUS-1:0] st_oe;
		logic                  rx_valid;
		logic [DATA_BITS-1:0]  rx_data;
		logic                  rx_err;
		logic [NUM_STATUS-1:0] st_in;
		logic                  powered;
		logic                  pwr_led;
		logic                  tx_led;
		logic                  rx_led;
	} dev_state_t;
	dev_state_t r;        // registered state
	dev_state_t next_r;   // next state
	logic                  on;          // serial link in service
	logic                  tx_start;    // character accepted for sending
	logic                  u_ready;     // transmitter ready
	logic                  u_rx_valid;  // character received
	logic [DATA_BITS-1:0]  u_rx_data;
	logic                  u_rx_err;
	logic                  u_txd;
	assign on       = (r.state == PWR_ON);
	assign tx_start = tx_valid_i && u_ready;
	// character engine; request-to-send, or any power state other than in service, holds the transmitter
	uart_char u_char (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.baud_div_i (baud_div_i),
		.tx_valid_i (tx_valid_i),
		.tx_data_i  (tx_data_i),
		.tx_hold_i  (r.sync2[S_RTS] || !on),
		.tx_ready_o (u_ready),
		.txd_o      (u_txd),
		.rxd_i      (r.sync2[S_TXD]),
		.rx_valid_o (u_rx_valid),
		.rx_data_o  (u_rx_data),
		.rx_err_o   (u_rx_err)
	);
	// next state: sequence, handshake and indicators
	always_comb begin
		next_r = r;
		// two-stage synchroniser for every link input
		next_r.sync1 = {link.power_request_in, link.host_reset_n, link.txd, link.dtr_n, link.rts, link.status_line};
		next_r.sync2 = r.sync1;
		next_r.tmr   = r.tmr + TMR_W'(1);
		// free running flash phase
		if (r.blink_cnt == TMR_W'(FLASH_CYCLES - 1)) begin
			next_r.blink_cnt = '0;
			next_r.blink     = !r.blink;
		end else begin
			next_r.blink_cnt = r.blink_cnt + TMR_W'(1);
		end
		// power sequence
		unique case (r.state)
			PWR_OFF: begin
				if (r.sync2[S_PWR] && r.sync2[S_RSTN]) begin
					next_r.state = PWR_START;
					next_r.tmr   = '0;
				end
			end
			PWR_START, PWR_ON: begin
				if (!r.sync2[S_PWR]) begin
					next_r.state = PWR_DOWN;
					next_r.tmr   = '0;
				end else if (!r.sync2[S_RSTN]) begin
					// held in start-up while reset is low
					next_r.state = PWR_START;
					next_r.tmr   = '0;
				end else if (r.state == PWR_START && r.tmr == TMR_W'(STARTUP_CYCLES - 1)) begin
					next_r.state = PWR_ON;
				end
			end
			PWR_DOWN: begin
				if (r.tmr == TMR_W'(POWERDOWN_CYCLES - 1)) begin
					next_r.state = PWR_OFF;
				end
			end
		endcase
		// activity stretchers
		next_r.tx_act = tx_start && on ? TMR_W'(ACT_CYCLES) : (r.tx_act != '0 ? r.tx_act - TMR_W'(1) : '0);
		next_r.rx_act = u_rx_valid && on ? TMR_W'(ACT_CYCLES) : (r.rx_act != '0 ? r.rx_act - TMR_W'(1) : '0);
		// handshake outputs; idle levels when not in service
		next_r.dcd_n  = !(on && in_range_i);
		next_r.dsr_n  = !on;
		next_r.cts    = !on || rx_pause_i;
		next_r.ring_n = !(on && msg_waiting_i && r.blink);
		// status lines stay undriven until the function is enabled
		next_r.st_o  = status_out_i;
		next_r.st_oe = (STATUS_LINES_ACTIVE && on) ? status_dir_i : '0;
		next_r.st_in = r.sync2[NUM_STATUS-1:0];
		// received data only delivered while in service
		next_r.rx_valid = u_rx_valid && on;
		if (u_rx_valid && on) begin
			next_r.rx_data = u_rx_data;
			next_r.rx_err  = u_rx_err;
		end
		next_r.powered = on;
		// indicators
		unique case (next_r.state)
			PWR_OFF: begin
				next_r.pwr_led = 1'b0;
				next_r.tx_led  = 1'b0;
				next_r.rx_led  = 1'b0;
			end
			PWR_START: begin
				// all flash whatever the disable says
				next_r.pwr_led = r.blink;
				next_r.tx_led  = r.blink;
				next_r.rx_led  = r.blink;
			end
			PWR_DOWN: begin
				next_r.pwr_led = 1'b0;
				next_r.tx_led  = r.blink;
				next_r.rx_led  = r.blink;
			end
			PWR_ON: begin
				// steady when locked, flashing while scanning; disable blanks all
				next_r.pwr_led = !led_disable_i && (channel_locked_i || r.blink);
				next_r.tx_led  = !led_disable_i && (r.tx_act != '0) && r.blink;
				next_r.rx_led  = !led_disable_i && (r.rx_act != '0) && r.blink;
			end
		endcase
	end
	// state register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{state: PWR_OFF, dcd_n: 1'b1, dsr_n: 1'b1, cts: 1'b1, ring_n: 1'b1, default: '0};
		end else begin
			r <= next_r;
		end
	end
	// link outputs; serial line idles high
	assign link.rxd           = u_txd;
	assign link.dcd_n         = r.dcd_n;
	assign link.dsr_n         = r.dsr_n;
	assign link.cts           = r.cts;
	assign link.ring_n        = r.ring_n;
	assign link.dev_status_o  = r.st_o;
	assign link.dev_status_oe = r.st_oe;
	// user outputs
	assign tx_ready_o  = u_ready;
	assign rx_valid_o  = r.rx_valid;
	assign rx_data_o   = r.rx_data;
	assign rx_err_o    = r.rx_err;
	assign status_in_o = r.st_in;
	assign powered_o   = r.powered;
	assign power_led_o = r.pwr_led;
	assign tx_led_o    = r.tx_led;
	assign rx_led_o    = r.rx_led;
endmodule

// File: src/modem_pkg.sv
// shared constants and types for the modem serial link and its host controller
package modem_pkg;
	// clock and timing
	localparam int CLK_HZ            = 50_000_000;         // core clock rate
	localparam int RESET_PULSE_MS    = 5;                  // least reset pulse width
	localparam int RESET_PULSE_CYC   = (RESET_PULSE_MS * (CLK_HZ / 1000)); // least time, exact in cycles
	localparam int STARTUP_MS        = 1000;               // start-up indicator flash time
	localparam int STARTUP_CYC       = STARTUP_MS * (CLK_HZ / 1000);
	localparam int POWERDOWN_MS      = 500;                // power-down indicator flash time
	localparam int POWERDOWN_CYC     = POWERDOWN_MS * (CLK_HZ / 1000);
	localparam int FLASH_HALF_MS     = 250;                // half period of indicator flashing
	localparam int FLASH_HALF_CYC    = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam int ACT_MS            = 100;                // activity stretch time
	localparam int ACT_CYC           = ACT_MS * (CLK_HZ / 1000);
	// character framing: 8 data bits, no parity, 1 stop bit
	localparam int DATA_BITS         = 8;
	localparam int STOP_BITS         = 1;
	localparam int FRAME_BITS        = 1 + DATA_BITS + STOP_BITS;
	localparam int BAUD_W            = 16;
	localparam logic [BAUD_W-1:0] DEF_BAUD_DIV = 16'h1458; // 9600 baud at 50 MHz
	localparam int TMR_W             = 32;
	localparam int NUM_STATUS        = 4;
	localparam logic STATUS_LINES_ACTIVE = 1'b0;           // status line function not active yet
	// host controller registers (byte addresses)
	localparam int ADDR_W            = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_BAUD   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_TXDATA = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_RXDATA = 8'h10;
	// control register fields
	localparam int CTRL_PWR          = 0;
	localparam int CTRL_RST          = 1;
	localparam int CTRL_PAUSE        = 2;
	localparam int CTRL_DTR          = 3;
	// status register fields
	localparam int ST_IN_RANGE       = 0;
	localparam int ST_DSR            = 1;
	localparam int ST_DEV_PAUSE      = 2;
	localparam int ST_RING           = 3;
	localparam int ST_TX_FREE        = 4;
	localparam int ST_RX_FULL        = 5;
	localparam int ST_RX_ERR         = 6;
	localparam int ST_RST_BUSY       = 7;
	// device power sequence
	typedef enum logic [1:0] {
		PWR_OFF   = 2'b00,
		PWR_START = 2'b01,
		PWR_ON    = 2'b10,
		PWR_DOWN  = 2'b11
	} pwr_state_t;
endpackage

// File: src/modem_link_if.sv
// host to modem data interface port: serial, handshake, power, reset and status lines
`timescale 1ns/1ps
interface modem_link_if;
	logic                  power_request_in;  // host to device, high powers on
	logic                  host_reset_n;      // host to device, low resets
	logic                  txd;               // host to device serial data
	logic                  dtr_n;             // host ready, low
	logic                  rts;               // host asks device to pause, high
	logic                  rxd;               // device to host serial data
	logic                  dcd_n;             // device in range, low
	logic                  dsr_n;             // device ready, low
	logic                  cts;               // device asks host to pause, high
	logic                  ring_n;            // messages waiting, pulses low
	logic [3:0]            dev_status_o;      // device drive value on status lines
	logic [3:0]            dev_status_oe;     // device drives status lines
	logic [3:0]            host_status_o;     // host drive value on status lines
	logic [3:0]            host_status_oe;    // host drives status lines
	logic [3:0]            status_line;       // resolved level, pulled up when undriven
	// wire resolution with pull-up
	assign status_line = (dev_status_oe & dev_status_o) | (~dev_status_oe & host_status_oe & host_status_o)
		| (~dev_status_oe & ~host_status_oe);
	modport device (
		input  power_request_in, host_reset_n, txd, dtr_n, rts, status_line,
		output rxd, dcd_n, dsr_n, cts, ring_n, dev_status_o, dev_status_oe
	);
	modport host (
		input  rxd, dcd_n, dsr_n, cts, ring_n, status_line,
		output power_request_in, host_reset_n, txd, dtr_n, rts, host_status_o, host_status_oe
	);
endinterface

// File: src/uart_char.sv
// 8N1 character transmitter and receiver with programmable bit time
`timescale 1ns/1ps
module uart_char import modem_pkg::*; (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	// bit time in clocks
	input  wire logic [BAUD_W-1:0]     baud_div_i,
	// transmit side
	input  wire logic                  tx_valid_i,
	input  wire logic [DATA_BITS-1:0]  tx_data_i,
	input  wire logic                  tx_hold_i,
	output logic                       tx_ready_o,
	output logic                       txd_o,
	// receive side, input already synchronised
	input  wire logic                  rxd_i,
	output logic                       rx_valid_o,
	output logic [DATA_BITS-1:0]       rx_data_o,
	output logic                       rx_err_o
);
	localparam logic [3:0] LAST_BIT = 4'(FRAME_BITS - 1);
	typedef struct packed {
		logic [BAUD_W-1:0]     tx_cnt;    // bit time counter
		logic [3:0]            tx_bit;    // bits left
		logic [FRAME_BITS-1:0] tx_sh;     // frame shifter, lsb on the line
		logic                  tx_busy;
		logic                  tx_ready;
		logic                  txd;
		logic [BAUD_W-1:0]     rx_cnt;
		logic [3:0]            rx_bit;
		logic [DATA_BITS-1:0]  rx_sh;
		logic                  rx_busy;
		logic                  rx_prev;   // last line level, for start edge
		logic                  rx_valid;
		logic [DATA_BITS-1:0]  rx_data;
		logic                  rx_err;
	} uart_state_t;
	uart_state_t r;        // registered state
	uart_state_t next_r;   // next state
	// next state for both directions
	always_comb begin
		next_r = r;
		next_r.rx_valid = 1'b0;
		// transmitter: start a frame only when not held off
		if (!r.tx_busy) begin
			if (tx_valid_i && r.tx_ready) begin
				next_r.tx_busy = 1'b1;
				next_r.tx_sh   = {1'b1, tx_data_i, 1'b0};
				next_r.tx_bit  = LAST_BIT;
				next_r.tx_cnt  = baud_div_i - BAUD_W'(1);
			end
		end else if (r.tx_cnt == '0) begin
			next_r.tx_cnt = baud_div_i - BAUD_W'(1);
			next_r.tx_sh  = {1'b1, r.tx_sh[FRAME_BITS-1:1]};
			next_r.tx_bit = r.tx_bit - 4'd1;
			if (r.tx_bit == '0) begin
				next_r.tx_busy = 1'b0;
			end
		end else begin
			next_r.tx_cnt = r.tx_cnt - BAUD_W'(1);
		end
		next_r.txd      = next_r.tx_busy ? next_r.tx_sh[0] : 1'b1;
		next_r.tx_ready = !next_r.tx_busy && !tx_hold_i;
		// receiver: start on falling edge, sample mid bit
		next_r.rx_prev = rxd_i;
		if (!r.rx_busy) begin
			if (r.rx_prev && !rxd_i) begin
				next_r.rx_busy = 1'b1;
				next_r.rx_bit  = LAST_BIT;
				next_r.rx_cnt  = baud_div_i >> 1;
			end
		end else if (r.rx_cnt == '0) begin
			next_r.rx_cnt = baud_div_i - BAUD_W'(1);
			next_r.rx_bit = r.rx_bit - 4'd1;
			if (r.rx_bit == LAST_BIT) begin
				// false start: line back high
				next_r.rx_busy = !rxd_i;
			end else if (r.rx_bit == '0) begin
				// stop bit: deliver, flag a low stop bit
				next_r.rx_busy  = 1'b0;
				next_r.rx_valid = 1'b1;
				next_r.rx_data  = r.rx_sh;
				next_r.rx_err   = !rxd_i;
			end else begin
				next_r.rx_sh = {rxd_i, r.rx_sh[DATA_BITS-1:1]};
			end
		end else begin
			next_r.rx_cnt = r.rx_cnt - BAUD_W'(1);
		end
	end
	// state register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{txd: 1'b1, rx_prev: 1'b1, default: '0};
		end else begin
			r <= next_r;
		end
	end
	assign tx_ready_o = r.tx_ready;
	assign txd_o      = r.txd;
	assign rx_valid_o = r.rx_valid;
	assign rx_data_o  = r.rx_data;
	assign rx_err_o   = r.rx_err;
endmodule

// File: src/modem_host.sv
// host end of the data interface port, commanded over APB
`timescale 1ns/1ps
module modem_host import modem_pkg::*; #(
	parameter int RESET_CYCLES = RESET_PULSE_CYC
) (
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// link to modem
	modem_link_if.host             link
);
	localparam int SYNC_W = 5 + NUM_STATUS;
	typedef struct packed {
		logic [SYNC_W-1:0]    sync1;     // first synchroniser stage
		logic [SYNC_W-1:0]    sync2;     // {rxd, dcd_n, dsr_n, cts, ring_n, status}
		logic                 pwr;       // power request wanted
		logic                 dtr;       // host ready wanted
		logic                 pause;     // ask modem to pause
		logic [BAUD_W-1:0]    baud;      // bit time in clocks
		logic [TMR_W-1:0]     rst_cnt;   // reset pulse remaining
		logic                 tx_pend;   // character waiting for transmitter
		logic [DATA_BITS-1:0] tx_data;
		logic                 rx_full;   // received character unread
		logic [DATA_BITS-1:0] rx_data;
		logic                 rx_err;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		logic                 power;     // link outputs
		logic                 reset_n;
		logic                 txd;
		logic                 dtr_n;
		logic                 rts;
	} host_state_t;
	host_state_t r;        // registered state
	host_state_t next_r;   // next state
	logic                 acc;         // APB access completes this edge
	logic                 u_ready;
	logic                 u_txd;
	logic                 u_rx_valid;
	logic [DATA_BITS-1:0] u_rx_data;
	logic                 u_rx_err;
	logic [31:0]          status;
	assign acc = psel_i && penable_i && r.pready;
	assign status = 32'({r.rst_cnt != '0, r.rx_err, r.rx_full, !r.tx_pend, !r.sync2[4], r.sync2[5],
		!r.sync2[6], !r.sync2[7]});
	// character engine; modem clear-to-send high holds the transmitter
	uart_char u_char (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.baud_div_i (r.baud),
		.tx_valid_i (r.tx_pend),
		.tx_data_i  (r.tx_data),
		.tx_hold_i  (r.sync2[5] || !r.pwr),
		.tx_ready_o (u_ready),
		.txd_o      (u_txd),
		.rxd_i      (r.sync2[SYNC_W-1]),
		.rx_valid_o (u_rx_valid),
		.rx_data_o  (u_rx_data),
		.rx_err_o   (u_rx_err)
	);
	// next state: register file, reset pulse, link drive
	always_comb begin
		next_r = r;
		next_r.sync1   = {link.rxd, link.dcd_n, link.dsr_n, link.cts, link.ring_n, link.status_line};
		next_r.sync2   = r.sync1;
		next_r.pready  = psel_i && penable_i && !r.pready;
		next_r.pslverr = 1'b0;
		if (r.rst_cnt != '0) begin
			next_r.rst_cnt = r.rst_cnt - TMR_W'(1);
		end
		if (r.tx_pend && u_ready) begin
			next_r.tx_pend = 1'b0;
		end
		// read data and error response captured as pready is raised; write actions at the completing edge
		if (psel_i && penable_i && !r.pready) begin
			next_r.pslverr = !(paddr_i inside {REG_CTRL, REG_BAUD, REG_STATUS, REG_TXDATA, REG_RXDATA});
			unique case (paddr_i)
				REG_CTRL:   next_r.prdata = 32'({r.dtr, r.pause, r.rst_cnt != '0, r.pwr});
				REG_BAUD:   next_r.prdata = 32'(r.baud);
				REG_STATUS: next_r.prdata = status;
				REG_RXDATA: next_r.prdata = 32'(r.rx_data);
				default:    next_r.prdata = '0;
			endcase
		end
		if (acc && pwrite_i) begin
			unique case (paddr_i)
				REG_CTRL: begin
					next_r.pwr   = pwdata_i[CTRL_PWR];
					next_r.pause = pwdata_i[CTRL_PAUSE];
					next_r.dtr   = pwdata_i[CTRL_DTR];
					if (pwdata_i[CTRL_RST]) begin
						next_r.rst_cnt = TMR_W'(RESET_CYCLES);
					end
				end
				REG_BAUD: next_r.baud = pwdata_i[BAUD_W-1:0];
				REG_TXDATA: begin
					// a write while one is waiting is dropped
					if (!r.tx_pend) begin
						next_r.tx_pend = 1'b1;
						next_r.tx_data = pwdata_i[DATA_BITS-1:0];
					end
				end
				default: ;
			endcase
		end
		// reading data frees the slot; a new character wins over the clear
		if (acc && !pwrite_i && paddr_i == REG_RXDATA) begin
			next_r.rx_full = 1'b0;
		end
		if (u_rx_valid) begin
			next_r.rx_full = 1'b1;
			next_r.rx_data = u_rx_data;
			next_r.rx_err  = u_rx_err;
		end
		// powered off: everything driven low
		next_r.power   = next_r.pwr;
		next_r.reset_n = next_r.pwr && (next_r.rst_cnt == '0);
		next_r.txd     = next_r.pwr && u_txd;
		next_r.dtr_n   = next_r.pwr && !next_r.dtr;
		next_r.rts     = next_r.pwr && next_r.pause;
	end
	// state register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// link inputs start at their idle high levels, so no false start bit follows reset
			r <= '{baud: DEF_BAUD_DIV, sync1: '1, sync2: '1, default: '0};
		end else begin
			r <= next_r;
		end
	end
	assign prdata_o            = r.prdata;
	assign pready_o            = r.pready;
	assign pslverr_o           = r.pslverr;
	assign link.power_request_in = r.power;
	assign link.host_reset_n   = r.reset_n;
	assign link.txd            = r.txd;
	assign link.dtr_n          = r.dtr_n;
	assign link.rts            = r.rts;
	assign link.host_status_o  = '0;
	assign link.host_status_oe = '0;
endmodule

// File: tb/modem_link_checker.sv
// assertions on the link between host and modem ends
`timescale 1ns/1ps
module modem_link_checker (
	// clock and reset
	input wire logic       core_clk_i,
	input wire logic       rst_i,
	// host driven lines
	input wire logic       power_request_in,
	input wire logic       host_reset_n,
	input wire logic       txd,
	input wire logic       rts,
	// modem driven lines
	input wire logic       rxd,
	input wire logic       dsr_n,
	input wire logic       cts,
	input wire logic       ring_n,
	input wire logic [3:0] dev_status_oe,
	input wire logic [3:0] status_line
);
	// all checks share the core clock and reset
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	chk_off_not_ready: assert property ((!power_request_in)[*8] |-> dsr_n)
		else $error("modem ready while power request low");
	chk_off_pauses_host: assert property ((!power_request_in)[*8] |-> cts)
		else $error("host not paused while modem off");
	chk_host_off_quiet: assert property (!power_request_in |-> !txd && !rts)
		else $error("host line high while modem off");
	chk_ring_in_service: assert property ($fell(ring_n) |-> !dsr_n)
		else $error("ring pulse outside service");
	chk_rx_bit_len: assert property ($fell(rxd) |-> (!rxd)[*8])
		else $error("short low bit on modem data");
	chk_tx_bit_len: assert property ($fell(txd) && power_request_in |-> (!txd)[*8])
		else $error("short low bit on host data");
	chk_status_released: assert property (dev_status_oe == 4'h0 && status_line == 4'hF)
		else $error("status line driven");
	chk_reset_pulse_len: assert property ($rose(host_reset_n) |-> $past(host_reset_n, 19) == 1'b0)
		else $error("reset pulse too short");
	// main scenarios reached
	cov_modem_char: cover property ($fell(rxd));
	cov_ring: cover property ($fell(ring_n));
	cov_reset_pulse: cover property ($fell(host_reset_n) && power_request_in);
endmodule

// File: tb/testbench.sv
// self-checking bench joining host and modem ends of the link
`timescale 1ns/1ps
module testbench;
	import modem_pkg::*;
	logic        core_clk_i, rst_i, psel, pen, pwr, pready, pslverr, err;
	logic [7:0]  paddr, tx_data, rx_data;
	logic [31:0] pwdata, prdata, rdata;
	logic        tx_valid, tx_ready, rx_valid, rx_err, powered, pause, msg, inr;
	logic        locked, led_off, pled, tled, rled;
	logic [3:0]  sdir, sout, status_in;
	logic [15:0] baud;
	int          failures, cmp_count, n;
	modem_link_if link ();
	modem_host #(.RESET_CYCLES(20)) modem_host_inst (.core_clk_i, .rst_i, .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .link(link.host));
	modem_device #(.STARTUP_CYCLES(200), .POWERDOWN_CYCLES(100), .FLASH_CYCLES(8), .ACT_CYCLES(50))
		modem_device_inst (.core_clk_i, .rst_i, .link(link.device), .baud_div_i(baud),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .rx_err_o(rx_err), .rx_pause_i(pause), .in_range_i(inr),
		.channel_locked_i(locked), .msg_waiting_i(msg), .led_disable_i(led_off), .status_dir_i(sdir),
		.status_out_i(sout), .status_in_o(status_in), .powered_o(powered), .power_led_o(pled),
		.tx_led_o(tled), .rx_led_o(rled));
	modem_link_checker modem_link_checker_inst (.core_clk_i, .rst_i, .power_request_in(link.power_request_in),
		.host_reset_n(link.host_reset_n), .txd(link.txd), .rts(link.rts), .rxd(link.rxd), .dsr_n(link.dsr_n),
		.cts(link.cts), .ring_n(link.ring_n), .dev_status_oe(link.dev_status_oe), .status_line(link.status_line));
	// compare one result, counting mismatches
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		pen <= 1'b1;
		do @(posedge core_clk_i); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask
	// verdict and end of run
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// 50 MHz core clock
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	// hang guard, far beyond the sequence length
	initial begin
		#200000;
		failures++;
		summarize();
	end
	// main sequence
	initial begin
		{rst_i, psel, pen, pwr, paddr, pwdata, tx_valid, tx_data, pause, msg, inr, locked, led_off, sout} = '0;
		{baud, sdir} = {16'h0010, 4'hF};
		rst_i = 1'b1;
		repeat (20) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(REG_BAUD, 32'h0000_1458);
		rd(8'h20, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, REG_BAUD, 32'h10);
		apb(1'b1, REG_CTRL, 32'h9);
		n = 0;
		while (link.dsr_n !== 1'b0 && n++ < 600) @(posedge core_clk_i);
		chk(powered, 1'b1);
		chk(link.dcd_n, 1'b1);
		inr <= 1'b1;
		locked <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		chk(link.dcd_n, 1'b0);
		chk(pled, 1'b1);
		apb(1'b1, REG_TXDATA, 32'hA5);
		n = 0;
		while (rx_valid !== 1'b1 && n++ < 400) @(posedge core_clk_i);
		chk({rx_err, rx_data}, 9'h0A5);
		n = 0;
		while (rled !== 1'b1 && n++ < 20) @(posedge core_clk_i);
		chk(rled, 1'b1);
		apb(1'b1, REG_CTRL, 32'hD);
		repeat (8) @(posedge core_clk_i);
		tx_valid <= 1'b1;
		tx_data <= 8'h3C;
		repeat (300) @(posedge core_clk_i);
		chk(tx_ready, 1'b0);
		rd(REG_STATUS, 32'h13);
		apb(1'b1, REG_CTRL, 32'h9);
		// character stays offered until the modem takes it
		do @(posedge core_clk_i); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
		repeat (300) @(posedge core_clk_i);
		rd(REG_RXDATA, 32'h3C);
		pause <= 1'b1;
		led_off <= 1'b1;
		repeat (10) @(posedge core_clk_i);
		chk({pled, tled, rled}, 3'b000);
		rd(REG_STATUS, 32'h17);
		msg <= 1'b1;
		n = 0;
		while (link.ring_n !== 1'b0 && n++ < 100) @(posedge core_clk_i);
		chk(link.ring_n, 1'b0);
		apb(1'b1, REG_CTRL, 32'hB);
		n = 0;
		while (link.dsr_n !== 1'b1 && n++ < 50) @(posedge core_clk_i);
		chk(link.dsr_n, 1'b1);
		while (pled !== 1'b1 && n++ < 80) @(posedge core_clk_i);
		chk(pled, 1'b1);
		while (link.dsr_n !== 1'b0 && n++ < 600) @(posedge core_clk_i);
		chk(link.dsr_n, 1'b0);
		apb(1'b1, REG_CTRL, 32'h0);
		repeat (12) @(posedge core_clk_i);
		chk({link.dsr_n, link.cts, link.txd, powered}, 4'b1100);
		chk(status_in, 4'hF);
		n = 0;
		while (tled !== 1'b1 && n++ < 20) @(posedge core_clk_i);
		chk(tled, 1'b1);
		summarize();
	end
endmodule
